// [hw/ufm_core.sv]
// Full-duplex serial port core: transmit, receive FIFO and register access
`timescale 1ns/1ps
`include "ufm_cfg.svh"
module ufm_core #(
  parameter int BIT_CYC = `UFM_BIT_CYC,
  parameter int DEPTH = `UFM_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // Serial line
  output logic serial_out_pin_o,
  input wire logic serial_in_pin_i
);
  import ufm_pkg::*;
  localparam int TW = 16; // Bit timer width
  localparam int FW = 10; // FIFO entry: ninth or stop bit, parity error, data
  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] mode; // Mode register
    logic ovr; // Overrun flag
    logic perr; // Parity error flag
    logic ren; // Receive enable
    logic tbx; // Transmit ninth bit
    logic ti; // Transmit done flag
    logic ri; // Receive ready flag
    logic [7:0] hold; // Transmit holding register
    logic hold_full; // Holding register occupied
    ufm_st_t txst; // Transmit sequencer
    logic [TW-1:0] ttmr; // Transmit bit timer
    logic [2:0] tbit; // Transmit data index
    logic [7:0] tsh; // Transmit shift byte
    logic tout; // Line output
    ufm_st_t rxst; // Receive sequencer
    logic [TW-1:0] rtmr; // Receive bit timer
    logic [2:0] rbit; // Receive data index
    logic [7:0] rsh; // Receive assembly byte
    logic r9; // Received extra or parity bit
    logic rs1; // Line synchroniser, first stage
    logic rs2; // Line synchroniser, second stage
    logic rprev; // Delayed copy for edge detect
    logic [7:0] rdat; // Read data
  } ufm_core_st_t;
  ufm_core_st_t s_q, s_d;

  // Decoded mode fields
  logic mce, pe, xbe, sbl, xtra;
  logic [1:0] dl;
  ufm_par_t pt;
  logic [2:0] last;
  // FIFO hookup
  logic push, pop, f_full;
  logic [FW-1:0] f_in, f_head;
  logic [CW-1:0] f_cnt;
  // Single-cycle events
  logic ev_ti, ev_ri, ev_ovr, ev_perr, ev_store, stop_ok, par_bad;

  // ****************************************
  // Helpers
  // ****************************************
  // Mask of the active data bits for a length code
  function automatic logic [7:0] dmask(input logic [1:0] len);
    dmask = 8'hff >> (`UFM_DL_TOP - len);
  endfunction

  // Parity bit for the active data bits and type
  function automatic logic parbit(input logic [7:0] d, input logic [1:0] len, input ufm_par_t ty);
    logic x;
    x = ^(d & dmask(len));
    unique case (ty)
      UFM_PAR_ODD: parbit = ~x;
      UFM_PAR_EVEN: parbit = x;
      UFM_PAR_MARK: parbit = 1'b1;
      UFM_PAR_SPACE: parbit = 1'b0;
    endcase
  endfunction

  // Stop time in cycles less one; 1.5 bits only for five-bit data
  function automatic logic [TW-1:0] stopc(input logic lng, input logic [1:0] len);
    if (!lng) begin
      stopc = TW'(BIT_CYC - 1);
    end else if (len == `UFM_DL_FIVE) begin
      stopc = TW'((3 * BIT_CYC) / 2 - 1);
    end else begin
      stopc = TW'(2 * BIT_CYC - 1);
    end
  endfunction

  assign dl = s_q.mode[`UFM_B_DL];
  assign last = `UFM_LAST_MIN + 3'(dl);
  assign pt = ufm_par_t'(s_q.mode[`UFM_B_PT]);
  assign mce = s_q.mode[`UFM_B_MCE];
  assign pe = s_q.mode[`UFM_B_PE];
  assign xbe = s_q.mode[`UFM_B_XBE];
  assign sbl = s_q.mode[`UFM_B_SBL];
  assign xtra = pe | xbe;

  // ****************************************
  // Receive FIFO
  // ****************************************
  ufm_rx_fifo #(
    .W(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_i(push),
    .push_data_i(f_in),
    .pop_i(pop),
    .head_o(f_head),
    .count_o(f_cnt),
    .full_o(f_full)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    {ev_ti, ev_ri, ev_ovr, ev_perr, ev_store, push, pop} = '0;
    // Only the second stage feeds logic
    s_d.rs1 = serial_in_pin_i;
    s_d.rs2 = s_q.rs1;
    s_d.rprev = s_q.rs2;
    stop_ok = s_q.rs2;
    par_bad = pe && (s_q.r9 != parbit(s_q.rsh, dl, pt));
    // keep extra bit or stop bit
    f_in = {(xbe && !pe) ? s_q.r9 : stop_ok, par_bad, s_q.rsh};
    if (s_q.ttmr != '0) begin
      s_d.ttmr = s_q.ttmr - 1'b1;
    end
    if (s_q.rtmr != '0) begin
      s_d.rtmr = s_q.rtmr - 1'b1;
    end
    // Transmit sequencer
    unique case (s_q.txst)
      UFM_IDLE: begin
        if (s_q.hold_full) begin
          s_d.tsh = s_q.hold;
          s_d.hold_full = 1'b0;
          s_d.txst = UFM_START;
          s_d.tout = 1'b0;
          s_d.ttmr = TW'(BIT_CYC - 1);
        end
      end
      UFM_START: begin
        if (s_q.ttmr == '0) begin
          s_d.txst = UFM_DATA;
          s_d.tbit = '0;
          s_d.tout = s_q.tsh[0];
          s_d.ttmr = TW'(BIT_CYC - 1);
        end
      end
      UFM_DATA: begin
        if (s_q.ttmr == '0) begin
          s_d.ttmr = TW'(BIT_CYC - 1);
          if (s_q.tbit != last) begin
            s_d.tbit = s_q.tbit + 1'b1;
            s_d.tout = s_q.tsh[s_d.tbit];
          end else if (xtra) begin
            s_d.txst = UFM_XTRA;
            s_d.tout = pe ? parbit(s_q.tsh, dl, pt) : s_q.tbx;
          end else begin
            s_d.txst = UFM_STOP;
            s_d.tout = 1'b1;
            s_d.ttmr = stopc(sbl, dl);
            ev_ti = 1'b1;
          end
        end
      end
      UFM_XTRA: begin
        if (s_q.ttmr == '0) begin
          s_d.txst = UFM_STOP;
          s_d.tout = 1'b1;
          s_d.ttmr = stopc(sbl, dl);
          ev_ti = 1'b1;
        end
      end
      UFM_STOP: begin
        if (s_q.ttmr == '0) begin
          s_d.txst = UFM_IDLE;
        end
      end
      default: begin
        s_d.txst = UFM_IDLE;
        s_d.tout = 1'b1;
      end
    endcase
    // Receive sequencer
    unique case (s_q.rxst)
      UFM_IDLE: begin
        if (s_q.ren && s_q.rprev && !s_q.rs2) begin
          s_d.rxst = UFM_START;
          s_d.rtmr = TW'(BIT_CYC / 2 - 1);
          s_d.rsh = '0;
        end
      end
      UFM_START: begin
        // A glitch shorter than half a bit is not a start
        if (s_q.rtmr == '0) begin
          s_d.rxst = s_q.rs2 ? UFM_IDLE : UFM_DATA;
          s_d.rbit = '0;
          s_d.rtmr = TW'(BIT_CYC - 1);
        end
      end
      UFM_DATA: begin
        if (s_q.rtmr == '0) begin
          s_d.rsh[s_q.rbit] = s_q.rs2;
          s_d.rbit = s_q.rbit + 1'b1;
          s_d.rtmr = TW'(BIT_CYC - 1);
          if (s_q.rbit == last) begin
            s_d.rxst = xtra ? UFM_XTRA : UFM_STOP;
          end
        end
      end
      UFM_XTRA: begin
        if (s_q.rtmr == '0) begin
          s_d.r9 = s_q.rs2;
          s_d.rxst = UFM_STOP;
          s_d.rtmr = TW'(BIT_CYC - 1);
        end
      end
      UFM_STOP: begin
        if (s_q.rtmr == '0) begin
          s_d.rxst = UFM_IDLE;
          if (stop_ok) begin
            if (f_full) begin
              ev_ovr = 1'b1;
            end else begin
              push = 1'b1;
              ev_store = 1'b1;
              ev_perr = par_bad;
              ev_ri = !mce || s_q.r9;
            end
          end
        end
      end
      default: begin
        s_d.rxst = UFM_IDLE;
      end
    endcase
    if (!s_q.ren) begin
      s_d.rxst = UFM_IDLE;
    end
    // Register port: read data live for one cycle only
    s_d.rdat = `UFM_BYTE_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        `UFM_A_CTRL: s_d.rdat = {s_q.ovr, s_q.perr, !s_q.hold_full, s_q.ren,
                                 s_q.tbx, f_head[FW-1], s_q.ti, s_q.ri};
        `UFM_A_DATA: begin
          s_d.rdat = f_head[7:0];
          pop = (f_cnt != '0);
        end
        `UFM_A_MODE: s_d.rdat = s_q.mode;
        default: s_d.rdat = `UFM_BYTE_ZERO;
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        `UFM_A_CTRL: begin
          s_d.ovr = wr_data_i[`UFM_B_OVR];
          s_d.perr = wr_data_i[`UFM_B_PERR];
          s_d.ren = wr_data_i[`UFM_B_REN];
          s_d.tbx = wr_data_i[`UFM_B_TBX];
          s_d.ti = wr_data_i[`UFM_B_TI];
          s_d.ri = wr_data_i[`UFM_B_RI] || (f_cnt > CW'(1));
        end
        `UFM_A_DATA: begin
          s_d.hold = wr_data_i;
          s_d.hold_full = 1'b1;
        end
        `UFM_A_MODE: s_d.mode = wr_data_i;
        default: s_d.mode = s_q.mode;
      endcase
    end
    // Hardware set wins over a software clear
    s_d.ti = s_d.ti | ev_ti;
    s_d.ri = s_d.ri | ev_ri;
    s_d.ovr = s_d.ovr | ev_ovr;
    s_d.perr = s_d.perr | ev_perr;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.mode <= `UFM_MODE_RST;
      s_q.tout <= 1'b1;
      s_q.rs1 <= 1'b1;
      s_q.rs2 <= 1'b1;
      s_q.rprev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rdat;
  assign serial_out_pin_o = s_q.tout;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_wr_clears_empty;
    wr_i && addr_i == `UFM_A_DATA |=> s_q.hold_full;
  endproperty
  a_wr_clears_empty: assert property (p_wr_clears_empty) else $error("write left holding empty");

  property p_idle_load;
    s_q.hold_full && s_q.txst == UFM_IDLE && !wr_i |=> !s_q.hold_full && s_q.txst == UFM_START;
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle shifter did not load");

  property p_hold_waits;
    s_q.hold_full && s_q.txst != UFM_IDLE |=> s_q.hold_full;
  endproperty
  a_hold_waits: assert property (p_hold_waits) else $error("held byte lost during frame");

  property p_ti_at_stop;
    s_q.txst != UFM_STOP ##1 s_q.txst == UFM_STOP |-> s_q.ti && s_q.tout;
  endproperty
  a_ti_at_stop: assert property (p_ti_at_stop) else $error("done flag missing at stop");

  property p_extra_val;
    s_q.txst == UFM_DATA ##1 s_q.txst == UFM_XTRA && !pe |-> s_q.tout == $past(s_q.tbx);
  endproperty
  a_extra_val: assert property (p_extra_val) else $error("extra bit value wrong");

  property p_par_val;
    s_q.txst == UFM_DATA ##1 s_q.txst == UFM_XTRA && pe |-> s_q.tout == parbit(s_q.tsh, dl, pt);
  endproperty
  a_par_val: assert property (p_par_val) else $error("parity bit wrong");

  property p_ren_gate;
    !s_q.ren |=> s_q.rxst == UFM_IDLE;
  endproperty
  a_ren_gate: assert property (p_ren_gate) else $error("receiver ran while disabled");

  property p_overrun;
    // A data read in the same cycle may still free one entry
    ev_ovr |=> s_q.ovr && f_cnt == $past(f_cnt) - CW'($past(pop));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_ri_holds;
    s_q.ri && f_cnt > CW'(1) |=> s_q.ri;
  endproperty
  a_ri_holds: assert property (p_ri_holds) else $error("receive flag cleared early");

  property p_start_low;
    s_q.txst == UFM_START |-> !s_q.tout;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_read_pops;
    rd_i && addr_i == `UFM_A_DATA && f_cnt != '0 && !push |=> f_cnt == $past(f_cnt) - CW'(1);
  endproperty
  a_read_pops: assert property (p_read_pops) else $error("read did not free entry");

  c_tx_frame: cover property (s_q.txst == UFM_STOP ##1 s_q.txst == UFM_IDLE);
  c_rx_store: cover property (ev_store && ev_ri);
  c_overrun: cover property (ev_ovr);
  c_fifo_full: cover property (f_full);
endmodule

// [pkg/ufm_cfg.svh]
// Register map, reset values, field positions and counts of the serial port core
`ifndef UFM_CFG_SVH
`define UFM_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define UFM_A_CTRL 8'hd2
`define UFM_A_DATA 8'hd3
`define UFM_A_MODE 8'he5
// ****************************************
// Reset values
// ****************************************
`define UFM_MODE_RST 8'h0c
`define UFM_BYTE_ZERO 8'h00
// ****************************************
// Control/status bit positions
// ****************************************
`define UFM_B_OVR 7
`define UFM_B_PERR 6
`define UFM_B_REN 4
`define UFM_B_TBX 3
`define UFM_B_TI 1
`define UFM_B_RI 0
// ****************************************
// Mode bit positions
// ****************************************
`define UFM_B_MCE 7
`define UFM_B_PT 6:5
`define UFM_B_PE 4
`define UFM_B_DL 3:2
`define UFM_B_XBE 1
`define UFM_B_SBL 0
// ****************************************
// Counts
// ****************************************
`define UFM_BIT_CYC 16
`define UFM_FIFO_DEPTH 3
`define UFM_LAST_MIN 3'h4
`define UFM_DL_FIVE 2'h0
`define UFM_DL_TOP 2'h3
`endif

// [pkg/ufm_pkg.sv]
// Types shared by the serial port core and its receive FIFO
package ufm_pkg;
  // Frame sequencer states, Gray from idle to stop via the extra bit
  typedef enum logic [2:0] {
    UFM_IDLE = 3'h0,
    UFM_START = 3'h1,
    UFM_DATA = 3'h3,
    UFM_XTRA = 3'h2,
    UFM_STOP = 3'h6
  } ufm_st_t;
  // Parity type selection codes
  typedef enum logic [1:0] {
    UFM_PAR_ODD = 2'h0,
    UFM_PAR_EVEN = 2'h1,
    UFM_PAR_MARK = 2'h2,
    UFM_PAR_SPACE = 2'h3
  } ufm_par_t;
endpackage

// [hw/ufm_rx_fifo.sv]
// Small receive FIFO built from flip-flops with an index per end
`timescale 1ns/1ps
`include "ufm_cfg.svh"
module ufm_rx_fifo #(
  parameter int W = 10,
  parameter int DEPTH = `UFM_FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Write side
  input wire logic push_i,
  input wire logic [W-1:0] push_data_i,
  // Read side
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic [CW-1:0] count_o,
  output logic full_o
);
  import ufm_pkg::*;
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Entries
    logic [AW-1:0] rp; // Oldest entry
    logic [AW-1:0] wp; // Next free entry
    logic [CW-1:0] cnt; // Entries held
  } ufm_fifo_st_t;
  ufm_fifo_st_t s_q, s_d;
  logic do_push, do_pop;

  // Wrapping index step, used by both ends
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Next state: a push into a full FIFO is dropped here, the core flags it
  always_comb begin
    s_d = s_q;
    do_push = push_i && (s_q.cnt != CW'(DEPTH));
    do_pop = pop_i && (s_q.cnt != '0);
    if (do_push) begin
      s_d.mem[s_q.wp] = push_data_i;
      s_d.wp = nxt(s_q.wp);
    end
    if (do_pop) begin
      s_d.rp = nxt(s_q.rp);
    end
    s_d.cnt = s_q.cnt + CW'(do_push) - CW'(do_pop);
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign head_o = s_q.mem[s_q.rp];
  assign count_o = s_q.cnt;
  assign full_o = (s_q.cnt == CW'(DEPTH));

  // ****************************************
  // Checks
  // ****************************************
  property p_fifo_bound;
    @(posedge clk_i) disable iff (!rst_b_i) s_q.cnt <= CW'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
endmodule

// [verification/ufm_peer.sv]
// Remote serial node model: sends frames to the core and decodes frames from it
`timescale 1ns/1ps
module ufm_peer #(
  parameter int BIT_CYC = 4
) (
  // Clock
  input wire logic clk_i,
  // Serial line
  input wire logic line_in_i,
  output logic line_out_o
);
  // ********
  // Line driver
  // ********
  // Idle line rests high, as a real transmitter leaves it
  initial line_out_o = 1'b1;

  // Hold one level for a whole bit time
  task automatic put_bit(input logic b);
    line_out_o <= b;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask

  task automatic send(input int nb, input bit has_x, input logic x, input logic stp, input logic [7:0] d);
    @(posedge clk_i);
    put_bit(1'b0);
    for (int i = 0; i < nb; i++) begin
      put_bit(d[i]);
    end
    if (has_x) begin
      put_bit(x);
    end
    put_bit(stp);
    // Two idle bits so a broken stop cannot merge with the next start
    put_bit(1'b1);
    put_bit(1'b1);
  endtask

  // ********
  // Line decoder
  // ********
  // centre sampling of frames
  task automatic recv(input int nb, input bit has_x, output logic [7:0] d, output logic x, output logic stp);
    int n;
    d = 8'h00;
    x = 1'b0;
    n = 0;
    @(posedge clk_i);
    // Bounded hunt for the start bit, so a silent line cannot hang us
    while (line_in_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      d[i] = line_in_i;
    end
    if (has_x) begin
      repeat (BIT_CYC) @(posedge clk_i);
      x = line_in_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    stp = line_in_i;
  endtask

  // stop run length
  // Counts the high cycles after the first low-to-high change that follows a start bit;
  // every wait is bounded so a stuck line cannot hang the run
  task automatic high_run(output int n);
    int k;
    n = 0;
    k = 0;
    @(posedge clk_i);
    while (line_in_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    while (line_in_i !== 1'b1 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    while (line_in_i === 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`include "ufm_cfg.svh"
module testbench;
  import ufm_pkg::*;
  // Short bit time keeps the run brief
  localparam int BC = 4;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rd_data_o;
  logic tx_line;
  logic rx_line;
  int errors = 0;
  int n_compared = 0;
  int nb;
  logic [7:0] d, dm;
  logic x, s, p;
  logic [7:0] rxb [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  ufm_core #(.BIT_CYC(BC), .DEPTH(`UFM_FIFO_DEPTH)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .serial_out_pin_o(tx_line), .serial_in_pin_i(rx_line));
  ufm_peer #(.BIT_CYC(BC)) peer (.clk_i(clk_i), .line_in_i(tx_line), .line_out_o(rx_line));

  // ********
  // Register access
  // ********
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rd_data_o;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read, mask and compare
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(nm, q & m, e);
  endtask

  task automatic complete_run();
    $display("Compared %0d values, %0d mismatches", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog: the tests need some 1500 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  // ********
  // Test sequence
  // ********
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Reset values and an unmapped place
    rchk("ctrl_rst", `UFM_A_CTRL, 8'hff, 8'h20);
    rchk("mode_rst", `UFM_A_MODE, 8'hff, `UFM_MODE_RST);
    wr(8'h00, 8'hff);
    rchk("unmapped", 8'h00, 8'hff, 8'h00);
    rchk("mode_kept", `UFM_A_MODE, 8'hff, `UFM_MODE_RST);
    // Back-to-back writes: the second waits in the holding register
    fork
      peer.recv(8, 1'b0, d, x, s);
      begin
        wr(`UFM_A_DATA, 8'ha5);
        wr(`UFM_A_DATA, 8'h3c);
        rchk("thre_wait", `UFM_A_CTRL, 8'h20, 8'h00);
      end
    join
    chk("tx_first", d, 8'ha5);
    chk("tx_stop", {7'h00, s}, 8'h01);
    // The held byte starts right after the stop, so the decoder must already be listening
    fork
      peer.recv(8, 1'b0, d, x, s);
      begin
        rchk("ti_set", `UFM_A_CTRL, 8'h02, 8'h02);
        wr(`UFM_A_CTRL, 8'h00);
      end
    join
    chk("tx_second", d, 8'h3c);
    rchk("ti_thre", `UFM_A_CTRL, 8'h22, 8'h22);
    // Every length and parity type, then the bare extra bit with both values
    for (int i = 0; i < 6; i++) begin
      nb = (i < 4) ? 5 + i : 8;
      dm = 8'hb6 & (8'hff >> (8 - nb));
      p = (i == 0) ? ~^dm : (i == 1) ? ^dm : (i == 2) ? 1'b1 : (i == 3) ? 1'b0 : (i == 4);
      wr(`UFM_A_MODE, (i < 4) ? {1'b0, 2'(i), 1'b1, 2'(i), 2'b10} : 8'h0e);
      wr(`UFM_A_CTRL, (i == 5) ? 8'h00 : 8'h08);
      fork
        peer.recv(nb, 1'b1, d, x, s);
        wr(`UFM_A_DATA, 8'hb6);
      join
      chk("tx_len", d, dm);
      chk("tx_extra", {7'h00, x}, {7'h00, p});
    end
    // Stop time: two queued frames, line high for the stop plus one idle cycle between them
    for (int i = 0; i < 3; i++) begin
      wr(`UFM_A_MODE, (i == 0) ? 8'h0d : (i == 1) ? 8'h01 : 8'h0c);
      fork
        peer.high_run(nb);
        begin
          wr(`UFM_A_DATA, 8'h00);
          wr(`UFM_A_DATA, 8'h00);
        end
      join
      // Let the second frame drain before the mode changes again
      repeat (12 * BC) @(posedge clk_i);
      chk("stop_len", 8'(nb), (i == 0) ? 8'(2 * BC + 1) : (i == 1) ? 8'(3 * BC / 2 + 1) : 8'(BC + 1));
    end
    // Four bytes into a three-byte FIFO
    wr(`UFM_A_MODE, 8'h0c);
    wr(`UFM_A_CTRL, 8'h10);
    foreach (rxb[k]) begin
      peer.send(8, 1'b0, 1'b0, 1'b1, rxb[k]);
    end
    rchk("rx_full", `UFM_A_CTRL, 8'hff, 8'hb5);
    wr(`UFM_A_CTRL, 8'h10);
    rchk("ri_kept", `UFM_A_CTRL, 8'hff, 8'h35);
    // Clear, read, recheck until the flag stays low
    for (int k = 0; k < 3; k++) begin
      wr(`UFM_A_CTRL, 8'h10);
      rchk("rx_data", `UFM_A_DATA, 8'hff, rxb[k]);
      rchk("rx_ready", `UFM_A_CTRL, 8'h01, (k < 2) ? 8'h01 : 8'h00);
    end
    // Frame with a low stop bit is dropped
    peer.send(8, 1'b0, 1'b0, 1'b0, 8'h5a);
    rchk("bad_stop", `UFM_A_CTRL, 8'h01, 8'h00);
    peer.send(8, 1'b0, 1'b0, 1'b1, 8'h66);
    rchk("after_bad", `UFM_A_DATA, 8'hff, 8'h66);
    // Even parity: wrong bit first, then right bit
    wr(`UFM_A_MODE, 8'h3c);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b1, 1'b0, 1'b1, 8'h07);
    rchk("perr_set", `UFM_A_CTRL, 8'h40, 8'h40);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b1, 1'b1, 1'b1, 8'h07);
    rchk("perr_clean", `UFM_A_CTRL, 8'h40, 8'h00);
    rchk("par_byte", `UFM_A_DATA, 8'hff, 8'h07);
    rchk("par_byte", `UFM_A_DATA, 8'hff, 8'h07);
    // Multidrop slave: filter and extra bit both on
    wr(`UFM_A_MODE, 8'h8e);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b1, 1'b0, 1'b1, 8'h42);
    rchk("md_data", `UFM_A_CTRL, 8'h01, 8'h00);
    peer.send(8, 1'b1, 1'b1, 1'b1, 8'ha1);
    rchk("md_addr", `UFM_A_CTRL, 8'h05, 8'h01);
    rchk("md_head", `UFM_A_DATA, 8'hff, 8'h42);
    rchk("md_rbx", `UFM_A_CTRL, 8'h04, 8'h04);
    rchk("md_head", `UFM_A_DATA, 8'hff, 8'ha1);
    // Address matched, so the filter is dropped for the data
    wr(`UFM_A_MODE, 8'h0e);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b1, 1'b0, 1'b1, 8'h55);
    rchk("md_open", `UFM_A_CTRL, 8'h05, 8'h01);
    rchk("md_byte", `UFM_A_DATA, 8'hff, 8'h55);
    // Receiver off: line ignored, held byte still readable
    wr(`UFM_A_MODE, 8'h0c);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b0, 1'b0, 1'b1, 8'h12);
    wr(`UFM_A_CTRL, 8'h00);
    peer.send(8, 1'b0, 1'b0, 1'b1, 8'h99);
    rchk("ren_read", `UFM_A_DATA, 8'hff, 8'h12);
    wr(`UFM_A_CTRL, 8'h10);
    peer.send(8, 1'b0, 1'b0, 1'b1, 8'h34);
    rchk("ren_back", `UFM_A_DATA, 8'hff, 8'h34);
    complete_run();
  end
endmodule
